// ===== logic/legacy_exception_debug_checks.sv
// Exception and debug register checking for a 32-bit core.
// Assumes the decode/execute pipeline presents one check request a cycle
// and a register master on the same clock that never needs to wait.
//
// Functional notes
// - Type 00 breaks on execution, 01 on data writes, 11 on reads or writes.
// - Type 10 breaks on I/O accesses with debug extensions on, else never.
// - Control bits 11, 12, 14 and 15 always read zero.
// - Status bit 12 cannot be set by a write.
// - Without debug extensions, registers four and five alias status, control.
// - With debug extensions, registers four and five raise invalid opcode.
// - Moves to or from test registers raise invalid opcode.
// - Vector FP computation faults report vector 19.
// - Machine check on vector 18 only while its enable is set; off at reset.
// - Writing one to a reserved special register bit raises vector 13.
// - Reserved bit in a paging entry raises page fault, vector 14.
// - Unaligned reference with alignment checking active raises vector 17.
// - Divide error on vector 0 saves the faulting instruction pointer.
// - Signed divide may yield 80H or 8000H without error.
// - Misused lock prefix raises invalid opcode, vector 6.
// - Instructions over 15 bytes raise general protection.
// - Switching to a 16-bit task keeps the page directory base.
// - Access-rights bytes 80H and 00H mark invalid descriptors.
// - Locked accessed-bit update only when the accessed bit is clear.
`timescale 1ns/1ps
module legacy_exception_debug_checks
	import exc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        req_valid,
	input  wire logic [31:0] req_ip,
	input  wire logic [4:0]  req_len,
	input  wire logic        req_lock_bad,
	input  wire logic        req_test_reg,
	input  wire logic        req_rsvd_write,
	input  wire logic        req_pte_rsvd,
	input  wire logic        req_unaligned,
	input  wire logic        req_align_flag,
	input  wire logic        req_simd_fp,
	input  wire logic        req_hw_err,
	input  wire logic        req_div,
	input  wire logic        req_div_word,
	input  wire logic        req_div_signed,
	input  wire logic [31:0] req_dividend,
	input  wire logic [15:0] req_divisor,
	input  wire acc_kind_e   req_acc_kind,
	input  wire logic [31:0] req_acc_addr,
	output logic             exc_valid,
	output logic      [7:0]  exc_vector,
	output logic      [31:0] exc_ip,
	output logic      [15:0] div_quotient,
	input  wire logic        desc_load,
	input  wire logic [7:0]  desc_ar,
	output logic             desc_invalid,
	output logic             lock_rmw_req,
	input  wire logic        ts_valid,
	input  wire logic        ts_32bit,
	input  wire logic [31:0] ts_dir_base,
	output logic      [31:0] page_directory_base
);
	chk_if ck ();

	logic [31:0] debug_status;
	logic [31:0] debug_control;
	logic [31:0] feature_control_register;
	logic [31:0] bp_addr [4];
	logic        debug_extensions_enable;
	logic        machine_check_enable;
	logic        align_enable;
	logic        reg_acc;
	logic        alias_hit;
	logic        alias_ud;
	logic [3:0]  eff_addr;
	logic        feat_gp;
	logic        next_valid;
	logic [7:0]  next_vector;
	logic [31:0] next_status;

	assign debug_extensions_enable = feature_control_register[FEAT_DBG_EXT];
	assign machine_check_enable    = feature_control_register[FEAT_MCHK];
	assign align_enable            = feature_control_register[FEAT_ALIGN];

	// Feed the breakpoint and divide units
	assign ck.acc_valid  = req_valid;
	assign ck.acc_kind   = req_acc_kind;
	assign ck.acc_addr   = req_acc_addr;
	assign ck.control    = debug_control;
	assign ck.dbg_ext    = debug_extensions_enable;
	assign ck.bp_addr    = bp_addr;
	assign ck.div_word   = req_div_word;
	assign ck.div_signed = req_div_signed;
	assign ck.dividend   = req_dividend;
	assign ck.divisor    = req_divisor;

	bp_match u_bp (
		.ck (ck.bp)
	);

	div_check u_div (
		.ck (ck.div)
	);

	// Register port address decode
	assign reg_acc   = reg_wr || reg_rd;
	assign alias_hit = reg_addr == ADDR_ALIAS4 || reg_addr == ADDR_ALIAS5;
	assign alias_ud  = reg_acc && alias_hit && debug_extensions_enable;

	always_comb begin
		if (reg_addr == ADDR_ALIAS4)
			eff_addr = ADDR_STATUS;
		else if (reg_addr == ADDR_ALIAS5)
			eff_addr = ADDR_CONTROL;
		else
			eff_addr = reg_addr;
	end

	// reserved feature bits refuse the write
	assign feat_gp = reg_wr && reg_addr == ADDR_FEATURE &&
		(reg_wdata & ~FEAT_MASK) != 32'h0;

	// Breakpoint address registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++)
				bp_addr[i] <= 32'h0000_0000;
		end else if (reg_wr && reg_addr < ADDR_ALIAS4) begin
			bp_addr[reg_addr[1:0]] <= reg_wdata;
		end
	end

	// Status: hits set bits, and a set wins over a same-cycle write
	always_comb begin
		next_status = debug_status;
		if (reg_wr && !alias_ud && eff_addr == ADDR_STATUS)
			// bit 12 left out of the write mask
			next_status = reg_wdata & STATUS_WMASK;
		next_status[3:0] = next_status[3:0] | ck.bp_hit;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			debug_status <= STATUS_RST;
		else
			debug_status <= next_status;
	end

	// Control register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			debug_control <= CONTROL_RST;
		end else if (reg_wr && !alias_ud && eff_addr == ADDR_CONTROL) begin
			debug_control <= reg_wdata & CONTROL_WMASK;
		end
	end

	// Feature register; machine check enable is clear after reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			feature_control_register <= FEATURE_RST;
		end else if (reg_wr && reg_addr == ADDR_FEATURE && !feat_gp) begin
			feature_control_register <= reg_wdata;
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			if (alias_ud)
				reg_rdata <= 32'h0000_0000;
			else if (eff_addr < ADDR_ALIAS4)
				reg_rdata <= bp_addr[eff_addr[1:0]];
			else if (eff_addr == ADDR_STATUS)
				reg_rdata <= debug_status;
			else if (eff_addr == ADDR_CONTROL)
				reg_rdata <= debug_control;
			else if (eff_addr == ADDR_FEATURE)
				reg_rdata <= feature_control_register;
			else if (eff_addr == ADDR_PDB)
				reg_rdata <= page_directory_base;
			else
				reg_rdata <= 32'h0000_0000;
		end
	end

	always_comb begin
		next_valid  = 1'b1;
		next_vector = VEC_OPC;
		if (alias_ud)
			next_vector = VEC_OPC;
		else if (feat_gp)
			next_vector = VEC_PROT;
		else if (!req_valid)
			next_valid = 1'b0;
		else if (req_hw_err && machine_check_enable)
			next_vector = VEC_MCHK;
		else if (req_lock_bad)
			next_vector = VEC_OPC;
		else if (req_test_reg)
			next_vector = VEC_OPC;
		else if (req_len > MAX_INSN_LEN)
			next_vector = VEC_PROT;
		// reserved bit write reported by pipeline
		else if (req_rsvd_write)
			next_vector = VEC_PROT;
		else if (req_pte_rsvd)
			next_vector = VEC_PAGE;
		else if (req_unaligned && req_align_flag && align_enable)
			next_vector = VEC_ALIGN;
		else if (req_div && ck.div_err)
			next_vector = VEC_DIV;
		else if (req_simd_fp)
			next_vector = VEC_SIMD;
		else
			next_valid = 1'b0;
	end

	// Exception report, one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			exc_valid  <= 1'b0;
			exc_vector <= VEC_DIV;
			exc_ip     <= 32'h0000_0000;
		end else begin
			exc_valid  <= next_valid;
			exc_vector <= next_vector;
			exc_ip     <= req_ip;
		end
	end

	// Quotient capture
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			div_quotient <= 16'h0000;
		else if (req_valid && req_div && !ck.div_err)
			div_quotient <= ck.quotient;
	end

	// Descriptor load checks
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			desc_invalid <= 1'b0;
			lock_rmw_req <= 1'b0;
		end else begin
			desc_invalid <= desc_load &&
				(desc_ar == AR_NULL || desc_ar == AR_NP);
			// locked update only when accessed is clear
			lock_rmw_req <= desc_load && desc_ar != AR_NULL &&
				desc_ar != AR_NP && !desc_ar[AR_ACCESSED];
		end
	end

	// Page directory base
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			page_directory_base <= 32'h0000_0000;
		end else if (ts_valid && ts_32bit) begin
			// only 32-bit segments carry a base
			page_directory_base <= ts_dir_base;
		end else if (reg_wr && reg_addr == ADDR_PDB) begin
			page_directory_base <= reg_wdata;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	a_alias_ud_raise: assert property (
		alias_ud |=> exc_valid && exc_vector == VEC_OPC)
		else $error("alias access did not raise invalid opcode");

	a_alias_read_map: assert property (
		reg_rd && reg_addr == ADDR_ALIAS4 && !debug_extensions_enable
		|=> reg_rdata == $past(debug_status))
		else $error("register four did not read status");

	a_ctrl_rsvd_zero: assert property (
		reg_rd && eff_addr == ADDR_CONTROL && !alias_ud
		|=> reg_rdata[15:14] == 2'h0 && reg_rdata[12:11] == 2'h0)
		else $error("control reserved bits read nonzero");

	a_status_b12: assert property (
		reg_wr && eff_addr == ADDR_STATUS && !alias_ud
		|=> !debug_status[12])
		else $error("status bit 12 became set");

	a_mc_gated: assert property (
		!machine_check_enable
		|=> !(exc_valid && exc_vector == VEC_MCHK))
		else $error("machine check raised while disabled");

	a_len_limit: assert property (
		req_valid && req_len > MAX_INSN_LEN |=> exc_valid)
		else $error("overlong instruction not faulted");

	a_div_min_ok: assert property (
		req_valid && req_div && req_div_signed && !req_div_word &&
		req_dividend[15:0] == 16'hFF80 && req_divisor[7:0] == 8'h01
		|=> !(exc_valid && exc_vector == VEC_DIV) &&
		div_quotient[7:0] == 8'h80)
		else $error("most negative byte quotient refused");

	a_div_ip: assert property (
		exc_valid && exc_vector == VEC_DIV
		|-> exc_ip == $past(req_ip) && $past(req_valid && req_div))
		else $error("divide error saved wrong pointer");

	a_pdb_16bit: assert property (
		ts_valid && !ts_32bit && !(reg_wr && reg_addr == ADDR_PDB)
		|=> $stable(page_directory_base))
		else $error("16-bit task switch changed base");

	a_desc_invalid: assert property (
		desc_load && (desc_ar == AR_NULL || desc_ar == AR_NP)
		|=> desc_invalid && !lock_rmw_req)
		else $error("invalid descriptor accepted");

	a_rmw_skip: assert property (
		desc_load && desc_ar[AR_ACCESSED] |=> !lock_rmw_req)
		else $error("locked write with accessed bit set");

	a_feat_gp: assert property (
		feat_gp |=> exc_valid && exc_vector == VEC_PROT &&
		$stable(feature_control_register))
		else $error("reserved feature write not refused");
endmodule

// ===== logic/exc_pkg.sv
// Constants shared by the exception and debug checking logic.
// Assumes a 32-bit core pipeline on the same clock and reset.
package exc_pkg;

	// Register port addresses (word index)
	localparam logic [3:0] ADDR_BP0     = 4'h0;
	localparam logic [3:0] ADDR_ALIAS4  = 4'h4;
	localparam logic [3:0] ADDR_ALIAS5  = 4'h5;
	localparam logic [3:0] ADDR_STATUS  = 4'h6;
	localparam logic [3:0] ADDR_CONTROL = 4'h7;
	localparam logic [3:0] ADDR_FEATURE = 4'h8;
	localparam logic [3:0] ADDR_PDB     = 4'h9;

	// Field positions of the feature control register
	localparam int FEAT_DBG_EXT = 3;
	localparam int FEAT_MCHK    = 6;
	localparam int FEAT_ALIGN   = 18;
	localparam logic [31:0] FEAT_MASK = 32'h0004_0048;

	// Writable bits and reset values of the debug registers
	localparam logic [31:0] STATUS_WMASK  = 32'h0000_E00F;
	localparam logic [31:0] CONTROL_WMASK = 32'hFFFF_23FF;
	localparam logic [31:0] STATUS_RST    = 32'h0000_0000;
	localparam logic [31:0] CONTROL_RST   = 32'h0000_0000;
	localparam logic [31:0] FEATURE_RST   = 32'h0000_0000;
	localparam int CTRL_TYPE_LSB = 16;

	// Breakpoint type field encodings
	localparam logic [1:0] BPT_EXEC  = 2'h0;
	localparam logic [1:0] BPT_WRITE = 2'h1;
	localparam logic [1:0] BPT_IO    = 2'h2;
	localparam logic [1:0] BPT_RDWR  = 2'h3;

	// Exception vectors
	localparam logic [7:0] VEC_DIV   = 8'h00;
	localparam logic [7:0] VEC_OPC   = 8'h06;
	localparam logic [7:0] VEC_PROT  = 8'h0D;
	localparam logic [7:0] VEC_PAGE  = 8'h0E;
	localparam logic [7:0] VEC_ALIGN = 8'h11;
	localparam logic [7:0] VEC_MCHK  = 8'h12;
	localparam logic [7:0] VEC_SIMD  = 8'h13;

	// Instruction length limit in bytes
	localparam logic [4:0] MAX_INSN_LEN = 5'h0F;

	// Descriptor access-rights values that mark unused entries
	localparam logic [7:0] AR_NULL = 8'h00;
	localparam logic [7:0] AR_NP   = 8'h80;
	localparam int AR_ACCESSED = 0;

	typedef enum logic [1:0] {ACC_FETCH, ACC_READ, ACC_WRITE, ACC_IO}
		acc_kind_e;

endpackage

// ===== logic/chk_if.sv
// Carrier between the checker top and its breakpoint and divide units.
// Assumes all three sit on one clock.
`timescale 1ns/1ps
interface chk_if;
	import exc_pkg::*;
	logic        acc_valid;
	acc_kind_e   acc_kind;
	logic [31:0] acc_addr;
	logic [31:0] control;
	logic        dbg_ext;
	logic [31:0] bp_addr [4];
	logic [3:0]  bp_hit;
	logic        div_word;
	logic        div_signed;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic        div_err;
	logic [15:0] quotient;

	modport core (output acc_valid, acc_kind, acc_addr, control, dbg_ext,
		bp_addr, div_word, div_signed, dividend, divisor,
		input bp_hit, div_err, quotient);
	modport bp (input acc_valid, acc_kind, acc_addr, control, dbg_ext,
		bp_addr, output bp_hit);
	modport div (input div_word, div_signed, dividend, divisor,
		output div_err, quotient);
endinterface

// ===== logic/bp_match.sv
// Breakpoint matcher: compares one access against four breakpoints.
// Assumes the access and control fields are stable for the cycle.
`timescale 1ns/1ps
module bp_match
	import exc_pkg::*;
(
	chk_if.bp ck
);
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_bp
			logic [1:0]  btype;
			logic [1:0]  blen;
			logic [31:0] mask;
			logic        kind_ok;
			assign btype = ck.control[CTRL_TYPE_LSB + 4*i +: 2];
			assign blen  = ck.control[CTRL_TYPE_LSB + 4*i + 2 +: 2];
			assign mask  = (blen == 2'h0) ? 32'hFFFF_FFFF :
				(blen == 2'h1) ? 32'hFFFF_FFFE : 32'hFFFF_FFFC;
			always_comb begin
				unique case (btype)
					BPT_EXEC:  kind_ok = ck.acc_kind == ACC_FETCH;
					BPT_WRITE: kind_ok = ck.acc_kind == ACC_WRITE;
					BPT_IO:    kind_ok = ck.dbg_ext && ck.acc_kind == ACC_IO;
					BPT_RDWR:  kind_ok = ck.acc_kind == ACC_READ ||
						ck.acc_kind == ACC_WRITE;
				endcase
			end
			// Hit needs an enable bit, the right kind and an address match
			assign ck.bp_hit[i] = ck.acc_valid && kind_ok &&
				(ck.control[2*i +: 2] != 2'h0) &&
				((ck.acc_addr & mask) == (ck.bp_addr[i] & mask));
		end
	endgenerate
endmodule

// ===== logic/div_check.sv
// Divide range checker for byte and word divides.
// Assumes the operands are held for the cycle in which they are checked.
`timescale 1ns/1ps
module div_check (
	chk_if.div ck
);
	logic signed [32:0] num;
	logic signed [32:0] den;
	logic signed [32:0] q;
	logic signed [32:0] lo;
	logic signed [32:0] hi;
	logic               zero;

	// Widen operands, divide, and test the quotient range
	always_comb begin
		if (ck.div_word) begin
			num = ck.div_signed ? {ck.dividend[31], ck.dividend} :
				{1'b0, ck.dividend};
			den = ck.div_signed ? {{17{ck.divisor[15]}}, ck.divisor} :
				{17'h0, ck.divisor};
			lo = ck.div_signed ? -33'sh8000 : 33'sh0;
			hi = ck.div_signed ? 33'sh7FFF : 33'shFFFF;
		end else begin
			num = ck.div_signed ? {{17{ck.dividend[15]}},
				ck.dividend[15:0]} : {17'h0, ck.dividend[15:0]};
			den = ck.div_signed ? {{25{ck.divisor[7]}}, ck.divisor[7:0]} :
				{25'h0, ck.divisor[7:0]};
			lo = ck.div_signed ? -33'sh80 : 33'sh0;
			hi = ck.div_signed ? 33'sh7F : 33'shFF;
		end
		zero = den == 33'sh0;
		q = num / (zero ? 33'sh1 : den);
	end

	// most negative quotient is in range
	assign ck.div_err  = zero || q > hi || q < lo;
	assign ck.quotient = q[15:0];
endmodule

// ===== verif/pipe_model.sv
// Decode/execute pipeline model that feeds the checker its requests.
// Assumes the checker samples on the rising edge of clk_sys.
`timescale 1ns/1ps
module pipe_model
	import exc_pkg::*;
(
	input  wire logic  clk_sys,
	output logic        req_valid,
	output logic [31:0] req_ip,
	output logic [4:0]  req_len,
	output logic [7:0]  req_flags,
	output logic        req_div,
	output logic        req_div_word,
	output logic        req_div_signed,
	output logic [31:0] req_dividend,
	output logic [15:0] req_divisor,
	output acc_kind_e   req_acc_kind,
	output logic [31:0] req_acc_addr,
	output logic        desc_load,
	output logic [7:0]  desc_ar,
	output logic        ts_valid,
	output logic        ts_32bit,
	output logic [31:0] ts_dir_base
);
	// Quiet state; data lines flip so stale values never look valid
	task automatic idle();
		{req_valid, req_div, desc_load, ts_valid} <= 4'h0;
		{req_div_word, req_div_signed, ts_32bit} <= 3'h0;
		req_flags <= 8'h00;
		req_len <= 5'h01;
		req_ip <= ~req_ip;
		req_acc_addr <= ~req_acc_addr;
		req_dividend <= ~req_dividend;
		req_divisor <= ~req_divisor;
		ts_dir_base <= ~ts_dir_base;
		desc_ar <= ~desc_ar;
	endtask

	// Known start pattern before the first quiet cycle
	initial begin
		{req_ip, req_acc_addr, req_dividend, ts_dir_base} = '0;
		{req_divisor, desc_ar} = '0;
		req_acc_kind = ACC_FETCH;
		idle();
	end

	// Hold the request over the taking edge, then go quiet
	task automatic take();
		@(posedge clk_sys);
		idle();
		#1;
	endtask

	task automatic check(input logic [7:0] f, input logic [4:0] len,
		input logic [31:0] ip);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_flags <= f;
		req_len <= len;
		req_ip <= ip;
		take();
	endtask

	task automatic divide(input logic w, s, input logic [31:0] dd,
		input logic [15:0] dv, input logic [31:0] ip);
		@(posedge clk_sys);
		{req_valid, req_div, req_div_word, req_div_signed} <= {2'h3, w, s};
		req_dividend <= dd;
		req_divisor <= dv;
		req_ip <= ip;
		take();
	endtask

	task automatic access(input acc_kind_e k, input logic [31:0] a);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_acc_kind <= k;
		req_acc_addr <= a;
		take();
	endtask

	task automatic descr(input logic [7:0] ar);
		@(posedge clk_sys);
		desc_load <= 1'b1;
		desc_ar <= ar;
		take();
	endtask

	task automatic tswitch(input logic w32, input logic [31:0] base);
		@(posedge clk_sys);
		{ts_valid, ts_32bit} <= {1'b1, w32};
		ts_dir_base <= base;
		take();
	endtask
endmodule

// ===== verif/legacy_exception_debug_checks_bench.sv
// Self-checking bench for the exception and debug checking block.
// Assumes the pipeline model drives requests; the bench owns registers.
`timescale 1ns/1ps
module legacy_exception_debug_checks_bench;
	import exc_pkg::*;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata, exc_ip, page_directory_base, req_ip;
	logic [31:0] req_dividend, req_acc_addr, ts_dir_base, ip_n, d;
	logic [15:0] div_quotient, req_divisor;
	logic [7:0]  exc_vector, req_flags, desc_ar;
	logic [4:0]  req_len;
	logic        exc_valid, desc_invalid, lock_rmw_req, req_valid, req_div;
	logic        req_div_word, req_div_signed, desc_load, ts_valid, ts_32bit;
	acc_kind_e   req_acc_kind;
	int          n_errors = 0;
	int          tests_run = 0;
	// Breakpoint cases: type, access kind, extensions on, hit expected
	localparam logic [5:0] BT [9] = '{6'b00_00_0_1, 6'b00_01_0_0,
		6'b01_10_0_1, 6'b01_01_0_0, 6'b11_01_0_1, 6'b11_00_0_0,
		6'b10_11_0_0, 6'b10_11_1_1, 6'b10_01_1_0};

	always #10 clk_sys = ~clk_sys;

	pipe_model pipe_u (.clk_sys, .req_valid, .req_ip, .req_len, .req_flags,
		.req_div, .req_div_word, .req_div_signed, .req_dividend,
		.req_divisor, .req_acc_kind, .req_acc_addr, .desc_load, .desc_ar,
		.ts_valid, .ts_32bit, .ts_dir_base);

	legacy_exception_debug_checks dut_u (.clk_sys, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_ip,
		.req_len, .req_lock_bad(req_flags[7]), .req_test_reg(req_flags[6]),
		.req_rsvd_write(req_flags[5]), .req_pte_rsvd(req_flags[4]),
		.req_unaligned(req_flags[3]), .req_align_flag(req_flags[2]),
		.req_simd_fp(req_flags[1]), .req_hw_err(req_flags[0]), .req_div,
		.req_div_word, .req_div_signed, .req_dividend, .req_divisor,
		.req_acc_kind, .req_acc_addr, .exc_valid, .exc_vector, .exc_ip,
		.div_quotient, .desc_load, .desc_ar, .desc_invalid, .lock_rmw_req,
		.ts_valid, .ts_32bit, .ts_dir_base, .page_directory_base);

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One-cycle register write and read, data the cycle after the strobe
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chk("reg_rdata", exp, v);
	endtask

	task automatic echk(input logic v, input logic [7:0] vec);
		chk("exc_valid", {31'h0, v}, {31'h0, exc_valid});
		if (v) begin
			chk("exc_vector", {24'h0, vec}, {24'h0, exc_vector});
		end
	endtask

	// Check request; the reported pointer is the checked instruction
	task automatic xr(input logic [7:0] f, input logic [4:0] len,
		input logic v, input logic [7:0] vec);
		ip_n = ip_n + 32'h4;
		pipe_u.check(f, len, ip_n);
		echk(v, vec);
		if (v) begin
			chk("exc_ip", ip_n, exc_ip);
		end
	endtask

	// Divide; byte quotients are compared on their low byte
	task automatic dv(input logic w, s, input logic [31:0] dd,
		input logic [15:0] dr, input logic v, input logic [15:0] q);
		ip_n = ip_n + 32'h4;
		pipe_u.divide(w, s, dd, dr, ip_n);
		echk(v, VEC_DIV);
		if (v) begin
			chk("exc_ip", ip_n, exc_ip);
		end else begin
			chk("div_quotient", {16'h0, w ? q : {8'h0, q[7:0]}},
				{16'h0, w ? div_quotient : {8'h0, div_quotient[7:0]}});
		end
	endtask

	task automatic dsc(input logic [7:0] ar, input logic inv, lck);
		pipe_u.descr(ar);
		chk("desc_invalid", {31'h0, inv}, {31'h0, desc_invalid});
		chk("lock_rmw_req", {31'h0, lck}, {31'h0, lock_rmw_req});
	endtask

	// Guard against a hang
	initial begin
		#200000;
		n_errors++;
		complete_run();
	end

	initial begin
		ip_n = 32'h0000_1000;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rchk(ADDR_STATUS, STATUS_RST);
		rchk(ADDR_CONTROL, CONTROL_RST);
		rchk(ADDR_FEATURE, FEATURE_RST);
		wr(ADDR_CONTROL, 32'hFFFF_FFFF);
		rchk(ADDR_CONTROL, CONTROL_WMASK);
		wr(ADDR_STATUS, 32'h0000_1000);
		rchk(ADDR_STATUS, 32'h0);
		wr(ADDR_ALIAS4, 32'hFFFF_FFFF);
		echk(1'b0, 8'h00);
		rchk(ADDR_STATUS, STATUS_WMASK);
		rchk(ADDR_ALIAS4, STATUS_WMASK);
		wr(ADDR_ALIAS5, 32'h0000_0003);
		rchk(ADDR_CONTROL, 32'h3);
		rchk(ADDR_ALIAS5, 32'h3);
		wr(4'hA, 32'hFFFF_FFFF);
		rchk(4'hA, 32'h0);
		wr(ADDR_FEATURE, 32'h8);
		rchk(ADDR_FEATURE, 32'h8);
		wr(ADDR_ALIAS4, 32'h1);
		echk(1'b1, VEC_OPC);
		rchk(ADDR_STATUS, STATUS_WMASK);
		rd(ADDR_ALIAS5, d);
		echk(1'b1, VEC_OPC);
		chk("alias_read", 32'h0, d);
		wr(ADDR_FEATURE, 32'h1);
		echk(1'b1, VEC_PROT);
		rchk(ADDR_FEATURE, 32'h8);
		wr(ADDR_FEATURE, 32'h0004_0000);
		xr(8'h80, 5'h01, 1'b1, VEC_OPC);
		xr(8'h40, 5'h01, 1'b1, VEC_OPC);
		xr(8'h20, 5'h01, 1'b1, VEC_PROT);
		xr(8'h10, 5'h01, 1'b1, VEC_PAGE);
		xr(8'h0C, 5'h01, 1'b1, VEC_ALIGN);
		xr(8'h08, 5'h01, 1'b0, 8'h00);
		xr(8'h02, 5'h01, 1'b1, VEC_SIMD);
		xr(8'h00, 5'h10, 1'b1, VEC_PROT);
		xr(8'h00, 5'h0F, 1'b0, 8'h00);
		xr(8'h90, 5'h10, 1'b1, VEC_OPC);
		xr(8'h12, 5'h01, 1'b1, VEC_PAGE);
		xr(8'h01, 5'h01, 1'b0, 8'h00);
		wr(ADDR_FEATURE, 32'h0004_0040);
		xr(8'h81, 5'h01, 1'b1, VEC_MCHK);
		dv(1'b0, 1'b1, 32'h0000_FF80, 16'h0001, 1'b0, 16'h0080);
		dv(1'b1, 1'b1, 32'hFFFF_8000, 16'h0001, 1'b0, 16'h8000);
		dv(1'b1, 1'b1, 32'hFFFF_0000, 16'h0002, 1'b0, 16'h8000);
		dv(1'b0, 1'b1, 32'h0000_0080, 16'h0001, 1'b1, 16'h0);
		dv(1'b1, 1'b1, 32'hFFFF_8000, 16'hFFFF, 1'b1, 16'h0);
		dv(1'b0, 1'b0, 32'h0000_00FF, 16'h0001, 1'b0, 16'h00FF);
		dv(1'b1, 1'b0, 32'h0001_0000, 16'h0001, 1'b1, 16'h0);
		dv(1'b1, 1'b0, 32'h0000_0010, 16'h0000, 1'b1, 16'h0);
		wr(ADDR_BP0, 32'h0000_0100);
		foreach (BT[i]) begin
			wr(ADDR_FEATURE, {28'h0, BT[i][1], 3'h0});
			wr(ADDR_CONTROL, {14'h0, BT[i][5:4], 16'h0001});
			wr(ADDR_STATUS, 32'h0);
			pipe_u.access(acc_kind_e'(BT[i][3:2]), 32'h0000_0100);
			rchk(ADDR_STATUS, {31'h0, BT[i][0]});
		end
		dsc(8'h00, 1'b1, 1'b0);
		dsc(8'h80, 1'b1, 1'b0);
		dsc(8'h93, 1'b0, 1'b0);
		dsc(8'h92, 1'b0, 1'b1);
		pipe_u.tswitch(1'b1, 32'h1234_5000);
		chk("pdb", 32'h1234_5000, page_directory_base);
		pipe_u.tswitch(1'b0, 32'hABCD_E000);
		chk("pdb", 32'h1234_5000, page_directory_base);
		complete_run();
	end
endmodule
